// File: inc/tcb_pkg.sv
// Package of the timer capture buffer: register indices, field positions,
// reset values and the state carriers shared by the top and the edge finder.
// Assumes a 32-bit APB master and word-aligned registers at four times the index.
package tcb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices (byte address is four times the index)
  localparam logic [29:0] IDX_MODE      = 30'h0000FF80;
  localparam logic [29:0] IDX_FLAG      = 30'h0000FF83;
  localparam logic [29:0] IDX_IOCTL_A   = 30'h0000FF84;
  localparam logic [29:0] IDX_IOCTL_C   = 30'h0000FF85;
  localparam logic [29:0] IDX_COUNT     = 30'h0000FF86;
  localparam logic [29:0] IDX_CAPTURE_A = 30'h0000FF88;
  localparam logic [29:0] IDX_BUFFER_C  = 30'h0000FF8C;
  localparam logic [29:0] IDX_IRQ_STAT  = 30'h0000FF90;
  localparam logic [29:0] IDX_IRQ_CLEAR = 30'h0000FF91;
  localparam logic [29:0] IDX_IRQ_EN    = 30'h0000FF92;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int MODE_RUN_BIT  = 7;
  localparam int MODE_BUF_BIT  = 4;
  localparam int FLAG_CAP_A    = 0;
  localparam int IO_FUNC_BIT   = 2;
  localparam int IRQ_CAP_A     = 0;
  localparam int IRQ_EVT_C     = 1;
  localparam int IRQ_OVF       = 2;
  localparam int IRQ_CMP_A     = 3;
  localparam int IRQ_W         = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Edge select codes and reset values
  localparam logic [1:0]  EDGE_RISE      = 2'h0;
  localparam logic [1:0]  EDGE_FALL      = 2'h1;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [15:0] GEN_RESET      = 16'h0000;
  localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
  localparam logic [15:0] COUNT_STEP     = 16'h0001;
  localparam logic [2:0]  IOCTL_RESET    = 3'h0;
  localparam logic [31:0] RDATA_RESET    = 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // State carriers
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } tcb_edge_state_type;

  typedef struct packed {
    logic        run;
    logic        buf_en;
    logic [2:0]  io_a;
    logic [2:0]  io_c;
    logic [15:0] count;
    logic [15:0] reg_a;
    logic [15:0] reg_c;
    logic        flag_a;
    logic        flag_seen;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_en;
    logic [31:0] rdata;
    logic        slverr;
  } tcb_state_type;

endpackage : tcb_pkg

// File: core/tcb_edge.sv
// Edge finder for one capture pin: two-stage synchroniser, one stored sample,
// and the edge selected by a two-bit code.
// Assumes the pin is asynchronous to clk_sys and held for over two periods.
`timescale 1ns/10ps
module tcb_edge (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Pin and selection
  input  wire logic       pin_async,
  input  wire logic [1:0] edge_sel,
  // Detected edge, one cycle
  output logic            edge_hit
);

  tcb_pkg::tcb_edge_state_type st_reg;
  tcb_pkg::tcb_edge_state_type st_next;
  logic rise;
  logic fall;

  ////////////////////////////////////////////////////////////////////////////
  // Meta stage feeds only the sync stage, so nothing sees a metastable value
  always_comb begin
    st_next      = st_reg;
    st_next.meta = pin_async;          // [RQ13]
    st_next.sync = st_reg.meta;        // [RQ13]
    st_next.prev = st_reg.sync;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Compare current and previous synchronised samples
  assign rise = st_reg.sync & ~st_reg.prev;  // [RQ13]
  assign fall = ~st_reg.sync & st_reg.prev;  // [RQ13]

  // Upper code bit means both edges
  always_comb begin
    if (edge_sel[1]) begin
      edge_hit = rise | fall;                 // [RQ3] [RQ12]
    end else if (edge_sel == tcb_pkg::EDGE_FALL) begin
      edge_hit = fall;                        // [RQ3] [RQ12]
    end else begin
      edge_hit = rise;                        // [RQ3] [RQ12]
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_pin_rise_hit: assert property ((edge_sel == tcb_pkg::EDGE_RISE) && $past(pin_async, 2) && !$past(pin_async, 3)
    && $past(st_reg.sync) == $past(pin_async, 3) |-> edge_hit) // [RQ12]
    else $error("rising edge not seen two cycles after pin change");
  a_edge_sel_fall: assert property (edge_hit && (edge_sel == tcb_pkg::EDGE_FALL) |-> !st_reg.sync) // [RQ3]
    else $error("falling select fired on a high sample");

endmodule : tcb_edge

// File: core/tcb_top.sv
// Timer capture buffer: 16-bit up-counter, capture register A, register C as
// capture, compare or buffer of A, a flag for A and a masked interrupt, on APB.
// Assumes a 32-bit APB3 master on clk_sys; capture pins are asynchronous.
//
// Behaviour
// RQ1: C function select 0 makes C a compare register, 1 a capture register.
// RQ2: Software gives C the same function as A when C buffers A.
// RQ3: C edge select: 00 rising, 01 falling, 1X both edges of pin C.
// RQ4: Counter is a 16-bit readable, writable up-counter, zero after reset.
// RQ5: Software uses only whole 16-bit accesses to counter, A and C.
// RQ6: A capture copies the current counter value into register A.
// RQ7: Buffered capture loads A from counter and moves old A into C.
// RQ8: Buffered transfers happen on the selected (default rising) edge of pin A.
// RQ9: Buffer enable 1 makes C the buffer of A; 0 leaves C independent.
// RQ10: Counter stops while run bit is 0 and counts while it is 1.
// RQ11: Capture sets flag A; reading 1 then writing 0 clears it.
// RQ12: A edge select: 00 rising, 01 falling, 1X both edges of pin A.
// RQ13: Capture pins are synchronised, edges found from successive samples.
// RQ14: Unbuffered capture C loads the counter on each selected pin C edge.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module tcb_top (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Capture pins
  input  wire logic        capture_pin_a,
  input  wire logic        capture_pin_c,
  // Interrupt
  output logic             irq
);

  tcb_pkg::tcb_state_type st_reg;
  tcb_pkg::tcb_state_type st_next;

  logic [1:0]  pins;
  logic [1:0]  edge_hit;
  logic [1:0]  edge_sel [2];
  logic [29:0] idx;
  logic        setup;
  logic        acc_wr;
  logic        acc_rd;
  logic        cnt_wr;
  logic        cap_a;
  logic        cap_c;
  logic        buf_cap;
  logic        cmp_a;
  logic        cmp_c;
  localparam int IRQ_WL = tcb_pkg::IRQ_W;

  logic        ovf;
  logic [IRQ_WL-1:0] events;

  ////////////////////////////////////////////////////////////////////////////
  // Edge finders, one per capture pin
  assign pins        = {capture_pin_c, capture_pin_a};
  assign edge_sel[0] = st_reg.io_a[1:0];
  assign edge_sel[1] = st_reg.io_c[1:0];

  for (genvar ch = 0; ch < 2; ch++) begin : g_pin
    tcb_edge u_edge (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .pin_async (pins[ch]),
      .edge_sel  (edge_sel[ch]),
      .edge_hit  (edge_hit[ch])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus phase decode; the access phase always completes in one cycle
  assign idx    = paddr[31:2];
  assign setup  = psel & ~penable;
  assign acc_wr = psel & penable & pwrite;
  assign acc_rd = psel & penable & ~pwrite;
  assign cnt_wr = acc_wr && (idx == tcb_pkg::IDX_COUNT);

  // Capture and compare events
  assign cap_a   = edge_hit[0] & st_reg.io_a[tcb_pkg::IO_FUNC_BIT];                   // [RQ6]
  assign buf_cap = cap_a & st_reg.buf_en;                                              // [RQ8] [RQ9]
  assign cap_c   = edge_hit[1] & st_reg.io_c[tcb_pkg::IO_FUNC_BIT] & ~st_reg.buf_en;  // [RQ1] [RQ14]
  assign cmp_a   = ~st_reg.io_a[tcb_pkg::IO_FUNC_BIT] & st_reg.run & (st_reg.count == st_reg.reg_a);
  assign cmp_c   = ~st_reg.io_c[tcb_pkg::IO_FUNC_BIT] & ~st_reg.buf_en & st_reg.run
                 & (st_reg.count == st_reg.reg_c);                                     // [RQ1]
  assign ovf     = st_reg.run & ~cnt_wr & (st_reg.count == tcb_pkg::COUNT_MAX);

  // Interrupt event vector in status layout
  always_comb begin
    events                     = '0;
    events[tcb_pkg::IRQ_CAP_A] = cap_a;
    events[tcb_pkg::IRQ_EVT_C] = cap_c | cmp_c;
    events[tcb_pkg::IRQ_OVF]   = ovf;
    events[tcb_pkg::IRQ_CMP_A] = cmp_a;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: software writes first, hardware events override after them, except the counter increment, which a write overrides
  always_comb begin
    st_next = st_reg;

    // Control registers
    if (acc_wr && (idx == tcb_pkg::IDX_MODE)) begin
      st_next.run    = pwdata[tcb_pkg::MODE_RUN_BIT];
      st_next.buf_en = pwdata[tcb_pkg::MODE_BUF_BIT];
    end
    if (acc_wr && (idx == tcb_pkg::IDX_IOCTL_A)) begin
      st_next.io_a = pwdata[2:0];
    end
    if (acc_wr && (idx == tcb_pkg::IDX_IOCTL_C)) begin
      st_next.io_c = pwdata[2:0];
    end
    if (acc_wr && (idx == tcb_pkg::IDX_IRQ_EN)) begin
      st_next.irq_en = pwdata[IRQ_WL-1:0];
    end

    // Counter: a write wins over the increment, which wraps at the top
    if (cnt_wr) begin
      st_next.count = pwdata[15:0];                          // [RQ4]
    end else if (st_reg.run) begin
      st_next.count = st_reg.count + tcb_pkg::COUNT_STEP;    // [RQ10]
    end

    // Register A: a capture wins over a write in the same cycle
    if (acc_wr && (idx == tcb_pkg::IDX_CAPTURE_A)) begin
      st_next.reg_a = pwdata[15:0];
    end
    if (cap_a) begin
      st_next.reg_a = st_reg.count;                          // [RQ6] [RQ7]
    end

    // Register C: buffer of A, or its own capture
    if (acc_wr && (idx == tcb_pkg::IDX_BUFFER_C)) begin
      st_next.reg_c = pwdata[15:0];
    end
    if (buf_cap) begin
      st_next.reg_c = st_reg.reg_a;                          // [RQ7] [RQ9]
    end else if (cap_c) begin
      st_next.reg_c = st_reg.count;                          // [RQ14]
    end

    // Flag A: read as one arms the clear, a zero write then clears
    if (acc_rd && (idx == tcb_pkg::IDX_FLAG) && st_reg.flag_a) begin
      st_next.flag_seen = 1'b1;                              // [RQ11]
    end
    if (acc_wr && (idx == tcb_pkg::IDX_FLAG) && !pwdata[tcb_pkg::FLAG_CAP_A] && st_reg.flag_seen) begin
      st_next.flag_a    = 1'b0;                              // [RQ11]
      st_next.flag_seen = 1'b0;
    end
    if (cap_a) begin
      st_next.flag_a = 1'b1;                                 // [RQ11]
    end

    // Interrupt status: clear by one-bits, a new event in the same cycle wins
    if (acc_wr && (idx == tcb_pkg::IDX_IRQ_CLEAR)) begin
      st_next.irq_stat = (st_reg.irq_stat & ~pwdata[IRQ_WL-1:0]) | events;
    end else begin
      st_next.irq_stat = st_reg.irq_stat | events;
    end

    // Read data and error are captured in the setup cycle
    if (setup) begin
      st_next.slverr = 1'b0;
      st_next.rdata  = tcb_pkg::RDATA_RESET;
      case (idx)
        tcb_pkg::IDX_MODE: begin
          st_next.rdata[tcb_pkg::MODE_RUN_BIT] = st_reg.run;
          st_next.rdata[tcb_pkg::MODE_BUF_BIT] = st_reg.buf_en;
        end
        tcb_pkg::IDX_FLAG: begin
          st_next.rdata[tcb_pkg::FLAG_CAP_A] = st_reg.flag_a;
        end
        tcb_pkg::IDX_IOCTL_A: begin
          st_next.rdata[2:0] = st_reg.io_a;
        end
        tcb_pkg::IDX_IOCTL_C: begin
          st_next.rdata[2:0] = st_reg.io_c;
        end
        tcb_pkg::IDX_COUNT: begin
          st_next.rdata[15:0] = st_reg.count;                // [RQ4]
        end
        tcb_pkg::IDX_CAPTURE_A: begin
          st_next.rdata[15:0] = st_reg.reg_a;
        end
        tcb_pkg::IDX_BUFFER_C: begin
          st_next.rdata[15:0] = st_reg.reg_c;
        end
        tcb_pkg::IDX_IRQ_STAT: begin
          st_next.rdata[IRQ_WL-1:0] = st_reg.irq_stat;
        end
        tcb_pkg::IDX_IRQ_CLEAR: begin
          st_next.rdata = tcb_pkg::RDATA_RESET;              // Write-only, reads zero
        end
        tcb_pkg::IDX_IRQ_EN: begin
          st_next.rdata[IRQ_WL-1:0] = st_reg.irq_en;
        end
        default: begin
          st_next.slverr = 1'b1;                             // Unmapped address
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg           <= '0;
      st_reg.count     <= tcb_pkg::COUNT_RESET;              // [RQ4]
      st_reg.reg_a     <= tcb_pkg::GEN_RESET;
      st_reg.reg_c     <= tcb_pkg::GEN_RESET;
      st_reg.io_a      <= tcb_pkg::IOCTL_RESET;
      st_reg.io_c      <= tcb_pkg::IOCTL_RESET;
      st_reg.rdata     <= tcb_pkg::RDATA_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; the data path stays registered, handshake is combinational
  assign prdata  = st_reg.rdata;
  assign pslverr = st_reg.slverr & psel & penable;
  assign pready  = psel & penable;
  assign irq     = |(st_reg.irq_stat & st_reg.irq_en);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_buffered_capture;
    st_reg.buf_en && st_reg.io_a[tcb_pkg::IO_FUNC_BIT] && edge_hit[0];
  endsequence

  sequence s_c_own_capture;
    !st_reg.buf_en && st_reg.io_c[tcb_pkg::IO_FUNC_BIT] && edge_hit[1];
  endsequence

  property p_count_steps;
    st_reg.run && !cnt_wr |=> st_reg.count == $past(st_reg.count) + tcb_pkg::COUNT_STEP;
  endproperty

  a_count_reset_zero: assert property ($past(rst) |-> st_reg.count == tcb_pkg::COUNT_RESET) // [RQ4]
    else $error("counter not zero after reset");
  a_count_runs: assert property (p_count_steps) // [RQ10]
    else $error("counter did not step while running");
  a_count_halts: assert property (!st_reg.run && !cnt_wr |=> $stable(st_reg.count)) // [RQ10]
    else $error("counter moved while stopped");
  a_count_write: assert property (cnt_wr |=> st_reg.count == $past(pwdata[15:0])) // [RQ4]
    else $error("counter write lost");
  a_capture_a_load: assert property (cap_a |=> st_reg.reg_a == $past(st_reg.count)) // [RQ6]
    else $error("register A did not take the counter");
  a_buffer_shift: assert property (s_buffered_capture |=> st_reg.reg_c == $past(st_reg.reg_a)
    && st_reg.reg_a == $past(st_reg.count)) // [RQ7]
    else $error("buffered capture did not shift A into C");
  a_buffer_pin_c_ignored: assert property (st_reg.buf_en && !edge_hit[0] && !(acc_wr && idx == tcb_pkg::IDX_BUFFER_C)
    |=> $stable(st_reg.reg_c)) // [RQ9]
    else $error("buffer C changed without a capture on pin A");
  a_capture_c_load: assert property (s_c_own_capture |=> st_reg.reg_c == $past(st_reg.count)) // [RQ14]
    else $error("register C did not take the counter");
  a_compare_c_event: assert property (cmp_c |=> st_reg.irq_stat[tcb_pkg::IRQ_EVT_C]) // [RQ1]
    else $error("compare match on C not flagged");
  a_compare_no_load: assert property (!st_reg.io_c[tcb_pkg::IO_FUNC_BIT] && !st_reg.buf_en
    && !(acc_wr && idx == tcb_pkg::IDX_BUFFER_C) |=> $stable(st_reg.reg_c)) // [RQ1]
    else $error("compare register C was loaded by hardware");
  a_flag_sets: assert property (cap_a |=> st_reg.flag_a ##1 st_reg.flag_a || $past(acc_wr)) // [RQ11]
    else $error("capture flag A not set by capture");
  a_flag_needs_read: assert property (!st_reg.flag_seen && !cap_a && st_reg.flag_a |=> st_reg.flag_a) // [RQ11]
    else $error("flag A cleared without a prior read");
  a_irq_follows: assert property ((st_reg.irq_stat & st_reg.irq_en) != '0 |-> irq ##1 irq || $past(acc_wr)) // [RQ11]
    else $error("interrupt not raised for an enabled status bit");

  ////////////////////////////////////////////////////////////////////////////
  // Flag, register, status and read path checks

  // Flag clear takes two accesses: a read that sees one, then a zero write
  sequence s_flag_read_one;
    acc_rd && idx == tcb_pkg::IDX_FLAG && st_reg.flag_a;
  endsequence

  sequence s_flag_write_zero;
    acc_wr && idx == tcb_pkg::IDX_FLAG && !pwdata[tcb_pkg::FLAG_CAP_A];
  endsequence

  a_flag_read_arms: assert property (s_flag_read_one |=> st_reg.flag_seen) // [RQ11]
    else $error("flag read as one did not arm the clear");
  a_flag_write_clears: assert property (s_flag_write_zero ##0 (st_reg.flag_seen && !cap_a)
    |=> !st_reg.flag_a) // [RQ11]
    else $error("flag A survived a zero write after a read");

  // Mode write moves run and buffer enable together
  a_mode_write: assert property (acc_wr && idx == tcb_pkg::IDX_MODE
    |=> st_reg.run == $past(pwdata[tcb_pkg::MODE_RUN_BIT])
    && st_reg.buf_en == $past(pwdata[tcb_pkg::MODE_BUF_BIT])) // [RQ9] [RQ10]
    else $error("mode write not taken");

  // Function select of C follows software
  a_ioctl_c_write: assert property (acc_wr && idx == tcb_pkg::IDX_IOCTL_C
    |=> st_reg.io_c == $past(pwdata[2:0])) // [RQ1]
    else $error("control C write not taken");

  // Register A holds unless captured or written
  a_reg_a_holds: assert property (!cap_a && !(acc_wr && idx == tcb_pkg::IDX_CAPTURE_A)
    |=> $stable(st_reg.reg_a)) // [RQ6]
    else $error("register A changed with no capture or write");

  // A software write lands only when no capture claims the register
  a_reg_a_write: assert property (acc_wr && idx == tcb_pkg::IDX_CAPTURE_A && !cap_a
    |=> st_reg.reg_a == $past(pwdata[15:0]))
    else $error("write of register A lost");
  a_reg_c_write: assert property (acc_wr && idx == tcb_pkg::IDX_BUFFER_C && !buf_cap && !cap_c
    |=> st_reg.reg_c == $past(pwdata[15:0]))
    else $error("write of register C lost");

  // Overflow wraps to zero and is recorded
  a_overflow_wraps: assert property (ovf |=> st_reg.count == tcb_pkg::COUNT_RESET
    && st_reg.irq_stat[tcb_pkg::IRQ_OVF]) // [RQ4]
    else $error("counter overflow not wrapped or not flagged");
  a_compare_a_event: assert property (cmp_a |=> st_reg.irq_stat[tcb_pkg::IRQ_CMP_A])
    else $error("compare match on A not flagged");

  // Status bits stay until a clear write, which drops only the written ones
  a_status_sticky: assert property (!(acc_wr && idx == tcb_pkg::IDX_IRQ_CLEAR)
    |=> (st_reg.irq_stat & $past(st_reg.irq_stat)) == $past(st_reg.irq_stat))
    else $error("status bit dropped without a clear write");
  a_status_clear: assert property (acc_wr && idx == tcb_pkg::IDX_IRQ_CLEAR
    |=> (st_reg.irq_stat & $past(pwdata[IRQ_WL-1:0]) & ~$past(events)) == '0)
    else $error("clear write left a status bit set");

  // Reads return the word seen at setup, upper bits zero
  a_count_read: assert property (setup && idx == tcb_pkg::IDX_COUNT
    |=> prdata == {16'h0000, $past(st_reg.count)}) // [RQ4]
    else $error("counter read returned a wrong word");
  a_flag_read: assert property (setup && idx == tcb_pkg::IDX_FLAG
    |=> prdata == {31'h0, $past(st_reg.flag_a)}) // [RQ11]
    else $error("flag read returned a wrong word");

endmodule : tcb_top

// File: verification/tcb_pin_drv.sv
// Far-side model: drives both capture pins from levels the bench requests.
// Assumes the bench waits out the selected lag before expecting a capture.
`timescale 1ns/10ps
module tcb_pin_drv (
  // Clock
  input  wire logic       clk_sys,
  // Requested levels and answer delay
  input  wire logic       want_a,
  input  wire logic       want_c,
  input  wire logic [2:0] lag,
  // Pins
  output logic            capture_pin_a,
  output logic            capture_pin_c
);
  logic [7:0] hist_a;
  logic [7:0] hist_c;

  ////////////////////////////////////////////////////////////////////////////
  // History lines let both pins answer one to eight cycles late, by the shared lag
  always_ff @(posedge clk_sys) begin
    hist_a <= {hist_a[6:0], want_a};
    hist_c <= {hist_c[6:0], want_c};
  end

  // Levels stay put for many cycles, as the synchroniser needs
  assign capture_pin_a = hist_a[lag];
  assign capture_pin_c = hist_c[lag];
endmodule : tcb_pin_drv

// File: verification/test_timer_capture_buffer.sv
// Self-checking bench of the timer capture buffer over APB with a pin model.
// Assumes zero-wait APB answers are waited for, and pins settle within 20 cycles.
`timescale 1ns/10ps
module test_timer_capture_buffer;
  logic        clk_sys, rst, psel, penable, pwrite;
  logic [31:0] paddr, pwdata, prdata;
  logic        pready, pslverr, irq, pin_a, pin_c, want_a, want_c;
  logic [2:0]  lag;
  logic [15:0] seed;
  logic [31:0] a_m, c_m, r, v;
  logic        e;
  logic [29:0] ix4 [4];
  int          n_errors, n_tests, i;

  ////////////////////////////////////////////////////////////////////////////
  // Design and pin model
  tcb_top u_tcb_top (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_pin_a(pin_a), .capture_pin_c(pin_c), .irq(irq));
  tcb_pin_drv u_tcb_pin_drv (.clk_sys(clk_sys), .want_a(want_a), .want_c(want_c),
    .lag(lag), .capture_pin_a(pin_a), .capture_pin_c(pin_c));

  // Clock, 10 ns period
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer of a whole word; held until pready, bounded by a count
  task automatic apb(input logic [29:0] ix, input logic w, input logic [31:0] d,
                     output logic [31:0] rd_d, output logic er);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= {ix, 2'h0};
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    rd_d    = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [29:0] ix, input logic [31:0] d);
    logic [31:0] x;
    logic        y;
    apb(ix, 1'b1, d, x, y);
  endtask : wr

  task automatic rd(input logic [29:0] ix, output logic [31:0] d);
    logic y;
    apb(ix, 1'b0, 32'h0, d, y);
  endtask : rd

  // Margin covers synchroniser, detector and the slowest pin lag
  task automatic pin(input int w, input logic l);
    if (w != 0) want_c <= l;
    else want_a <= l;
    repeat (20) @(posedge clk_sys);
  endtask : pin

  // Rise then fall on one pin with the counter parked at a fresh value
  task automatic edge_case(input int w, input logic [1:0] sel);
    logic [29:0] ix;
    logic [31:0] cur, q;
    int          k;
    ix = (w != 0) ? tcb_pkg::IDX_BUFFER_C : tcb_pkg::IDX_CAPTURE_A;
    wr((w != 0) ? tcb_pkg::IDX_IOCTL_C : tcb_pkg::IDX_IOCTL_A, {29'h0, 1'b1, sel});
    wr(ix, 32'h0);
    cur = 32'h0;
    for (k = 1; k >= 0; k--) begin
      q = {16'h0, rnd()};
      wr(tcb_pkg::IDX_COUNT, q);
      pin(w, k[0]);
      if ((k == 1 && sel != 2'h1) || (k == 0 && sel != 2'h0)) cur = q;
      rd(ix, r);
      chk(r, cur);
    end
  endtask : edge_case

  task automatic summarize();
    if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, well beyond the under one thousand cycles the tests take
  initial begin
    #200000;
    n_errors++;
    summarize();
  end

  // Main sequence
  initial begin
    {rst, psel, penable, pwrite, want_a, want_c} = 6'h20;
    {paddr, pwdata} = 64'h0;
    lag = 3'h0;
    seed = 16'h4C9C;
    n_errors = 0;
    n_tests = 0;
    ix4 = '{tcb_pkg::IDX_COUNT, tcb_pkg::IDX_CAPTURE_A, tcb_pkg::IDX_BUFFER_C, tcb_pkg::IDX_IOCTL_C};
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values, then random write and read back
    for (i = 0; i < 4; i++) begin
      rd(ix4[i], r);
      chk(r, 32'h0);
      v = {16'h0, rnd()};
      wr(ix4[i], v);
      rd(ix4[i], r);
      chk(r, (i == 3) ? (v & 32'h7) : v);
    end
    // Unmapped place refuses
    apb(30'h0000FF81, 1'b0, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    // Every edge code on both pins
    for (i = 0; i < 4; i++) begin
      edge_case(0, i[1:0]);
      edge_case(1, i[1:0]);
    end
    // Compare mode: pin C leaves register C alone
    wr(tcb_pkg::IDX_IOCTL_C, 32'h0);
    wr(tcb_pkg::IDX_BUFFER_C, 32'h1234);
    pin(1, 1'b1);
    pin(1, 1'b0);
    rd(tcb_pkg::IDX_BUFFER_C, r);
    chk(r, 32'h1234);
    // Flag needs a read of 1 before the clearing write
    wr(tcb_pkg::IDX_FLAG, 32'h0);
    rd(tcb_pkg::IDX_FLAG, r);
    chk(r, 32'h1);
    wr(tcb_pkg::IDX_FLAG, 32'h0);
    rd(tcb_pkg::IDX_FLAG, r);
    chk(r, 32'h0);
    // Interrupt: status, enable, clear
    rd(tcb_pkg::IDX_IRQ_STAT, r);
    chk(r, 32'h3);
    for (i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      wr(tcb_pkg::IDX_IRQ_EN, 32'h1 << i);
      @(posedge clk_sys);
      chk({31'h0, irq}, 32'h1);
      wr(tcb_pkg::IDX_IRQ_CLEAR, 32'h1 << i);
      @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
    end
    rd(tcb_pkg::IDX_IRQ_STAT, r);
    chk(r, 32'h0);
    // Buffered: C follows old A, pin C ignored; software sets both to capture
    lag <= 3'h5;
    wr(tcb_pkg::IDX_MODE, 32'h10);
    wr(tcb_pkg::IDX_IOCTL_A, 32'h4);
    wr(tcb_pkg::IDX_IOCTL_C, 32'h4);
    a_m = {16'h0, rnd()};
    wr(tcb_pkg::IDX_CAPTURE_A, a_m);
    for (i = 0; i < 2; i++) begin
      c_m = a_m;
      a_m = {16'h0, rnd()};
      wr(tcb_pkg::IDX_COUNT, a_m);
      pin(0, 1'b1);
      pin(1, 1'b1);
      pin(0, 1'b0);
      pin(1, 1'b0);
      rd(tcb_pkg::IDX_CAPTURE_A, r);
      chk(r, a_m);
      rd(tcb_pkg::IDX_BUFFER_C, r);
      chk(r, c_m);
    end
    // Run bit: two reads three cycles apart differ by three, or by none
    for (i = 0; i < 2; i++) begin
      wr(tcb_pkg::IDX_COUNT, 32'h10);
      wr(tcb_pkg::IDX_MODE, (i == 0) ? 32'h80 : 32'h0);
      rd(tcb_pkg::IDX_COUNT, r);
      rd(tcb_pkg::IDX_COUNT, v);
      chk(v - r, (i == 0) ? 32'h3 : 32'h0);
    end
    // Overflow and both compare matches set their status bits, nothing else
    wr(tcb_pkg::IDX_IOCTL_A, 32'h0);
    wr(tcb_pkg::IDX_IOCTL_C, 32'h0);
    wr(tcb_pkg::IDX_CAPTURE_A, 32'hFFF8);
    wr(tcb_pkg::IDX_BUFFER_C, 32'hFFFA);
    wr(tcb_pkg::IDX_COUNT, 32'hFFF0);
    wr(tcb_pkg::IDX_IRQ_CLEAR, 32'hF);
    wr(tcb_pkg::IDX_MODE, 32'h80);
    repeat (32) @(posedge clk_sys);
    wr(tcb_pkg::IDX_MODE, 32'h0);
    rd(tcb_pkg::IDX_IRQ_STAT, r);
    chk(r, 32'hE);
    // Mid-run reset while counting: counter and status back to zero
    wr(tcb_pkg::IDX_MODE, 32'h80);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(tcb_pkg::IDX_COUNT, r);
    chk(r, 32'h0);
    rd(tcb_pkg::IDX_IRQ_STAT, r);
    chk(r, 32'h0);
    summarize();
  end
endmodule : test_timer_capture_buffer
